//--- src/sdm_pkg.sv
// shared constants for the stream memory dma option core
package sdm_pkg;
  localparam logic [31:0] OFF_CTRL      = 32'h00;
  localparam logic [31:0] OFF_STATUS    = 32'h04;
  localparam logic [31:0] OFF_RD_ADDR   = 32'h08;
  localparam logic [31:0] OFF_RD_LEN    = 32'h0c;
  localparam logic [31:0] OFF_WR_ADDR   = 32'h10;
  localparam logic [31:0] OFF_WR_LEN    = 32'h14;
  localparam logic [31:0] OFF_TICKS     = 32'h18;
  localparam logic [31:0] OFF_CONFIG    = 32'h1c;
  // control register fields
  localparam int          CTRL_TICK_EN  = 0;
  localparam int          CTRL_SOF      = 1;
  localparam int          CTRL_W        = 2;
  localparam logic [1:0]  RST_CTRL      = 2'h0;
  // status: live busy bits, then sticky flags
  localparam int          ST_RD_BUSY    = 0;
  localparam int          ST_WR_BUSY    = 1;
  localparam int          ST_STK_BASE   = 2;
  localparam int          STK_RD_DONE   = 0;
  localparam int          STK_WR_DONE   = 1;
  localparam int          STK_RD_ALIGN  = 2;
  localparam int          STK_WR_ALIGN  = 3;
  localparam int          STK_FRAME_END = 4;
  localparam int          STK_W         = 5;
  localparam logic [4:0]  RST_STK       = 5'h00;
  // config readback fields
  localparam int          CFG_FLAGS_W   = 5;
  localparam int          CFG_LEN_LSB   = 8;
  localparam logic [31:0] RST_WORD      = 32'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  // documented defaults and limits
  localparam int          DEF_LEN_W     = 14;
  localparam int          DEF_DLY_RES   = 125;
  localparam int          DEF_MM_W      = 32;
  localparam int          DEF_STRM_W    = 32;
  localparam int          DEF_MAX_BURST = 16;
  localparam int          REALIGN_MAX_W = 64;
  localparam int          BEATS_W       = 9;
  localparam int          OFS_W         = 3;
endpackage

//--- src/sdm_cmd_if.sv
// command handshake between register side and a burst splitter
`timescale 1ns/100ps
`default_nettype none
interface sdm_cmd_if #(
  parameter int LW = sdm_pkg::DEF_LEN_W
);
  logic                         start;
  logic [31:0]                  addr;
  logic [LW-1:0]                len;
  logic                         busy;
  logic                         done;
  logic                         align_err;
  logic [31:0]                  cmd_addr;
  logic [sdm_pkg::BEATS_W-1:0]  cmd_beats;
  logic                         cmd_valid;
  logic                         cmd_ready;
  logic [sdm_pkg::OFS_W-1:0]    ofs;
  modport ctl (output start, addr, len, cmd_ready, input busy, done,
               align_err, cmd_addr, cmd_beats, cmd_valid, ofs);
  modport eng (input start, addr, len, cmd_ready, output busy, done,
               align_err, cmd_addr, cmd_beats, cmd_valid, ofs);
endinterface
`default_nettype wire

//--- src/sdm_burst_split.sv
// burst splitter: one channel's transfer cut into bounded bursts
`timescale 1ns/100ps
`default_nettype none
module sdm_burst_split #(
  parameter int MM_W      = sdm_pkg::DEF_MM_W,
  parameter int STRM_W    = sdm_pkg::DEF_STRM_W,
  parameter int MAX_BURST = sdm_pkg::DEF_MAX_BURST,
  parameter int LEN_W     = sdm_pkg::DEF_LEN_W,
  parameter int REALIGN   = 1
) (
  input wire logic clk,
  input wire logic resetn,
  sdm_cmd_if.eng   port
);
  localparam int          BPB   = MM_W / 8;
  localparam int          BSH   = $clog2(BPB);
  localparam int          RW    = LEN_W + 2;
  localparam int          BW    = sdm_pkg::BEATS_W;
  localparam int          OW    = sdm_pkg::OFS_W;
  localparam logic [31:0] BMASK = 32'(BPB - 1);
  localparam logic [31:0] SMASK = 32'(STRM_W / 8 - 1);
  // realigner exists only for narrow streams
  localparam bit REAL_OK = (REALIGN != 0)
                        && (STRM_W <= sdm_pkg::REALIGN_MAX_W);

  typedef enum logic {SPL_IDLE, SPL_ISSUE} sdm_spl_t;

  sdm_spl_t          state_q;
  logic [RW-1:0]     rem_q, total, left;
  logic [31:0]       cur_q, nxt;
  logic [BW-1:0]     beats_q;
  logic [OW-1:0]     ofs_q;
  logic              valid_q, done_q, err_q, misalign, take, last;

  function automatic logic [BW-1:0] cap(input logic [RW-1:0] n);
    cap = (n > RW'(MAX_BURST)) ? BW'(MAX_BURST) : BW'(n);
  endfunction

  function automatic bit mm_ok(input int w);
    mm_ok = (w == 32) || (w == 64) || (w == 128) || (w == 256)
         || (w == 512) || (w == 1024);
  endfunction

  function automatic bit strm_ok(input int w, input int mm);
    strm_ok = ((w == 8) || (w == 16) || (w == 32) || (w == 64)
            || (w == 128) || (w == 512) || (w == 1024)) && (w <= mm);
  endfunction

  // aligned means a multiple of the stream width in bytes
  assign misalign = !REAL_OK && ((port.addr & SMASK) != 32'h0);
  // offset bytes count into the first beat
  assign total = (RW'(port.len) + RW'(port.addr & BMASK)
               + RW'(BPB - 1)) >> BSH;
  assign take  = valid_q && port.cmd_ready;
  assign left  = rem_q - RW'(beats_q);
  assign last  = (left == '0);
  assign nxt   = (cur_q & ~BMASK) + (32'(beats_q) << BSH);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= SPL_IDLE;
      rem_q   <= '0;
      cur_q   <= '0;
      beats_q <= '0;
      ofs_q   <= '0;
      valid_q <= 1'b0;
      done_q  <= 1'b0;
      err_q   <= 1'b0;
    end else begin
      done_q <= 1'b0;
      err_q  <= 1'b0;
      case (state_q)
        SPL_IDLE: begin
          if (port.start && misalign) begin
            err_q <= 1'b1;
          end else if (port.start && total == '0) begin
            done_q <= 1'b1;
          end else if (port.start) begin
            state_q <= SPL_ISSUE;
            rem_q   <= total;
            cur_q   <= port.addr;
            beats_q <= cap(total);
            valid_q <= 1'b1;
            ofs_q   <= REAL_OK ? OW'(port.addr & SMASK) : '0;
          end
        end
        SPL_ISSUE: begin
          if (take && last) begin
            state_q <= SPL_IDLE;
            valid_q <= 1'b0;
            done_q  <= 1'b1;
          end else if (take) begin
            rem_q   <= left;
            cur_q   <= nxt;
            beats_q <= cap(left);
          end
        end
        default: state_q <= SPL_IDLE;
      endcase
    end
  end

  assign port.busy      = (state_q == SPL_ISSUE);
  assign port.done      = done_q;
  assign port.align_err = err_q;
  assign port.cmd_addr  = cur_q;
  assign port.cmd_beats = beats_q;
  assign port.cmd_valid = valid_q;
  assign port.ofs       = ofs_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  width_a: assert property (
    mm_ok(MM_W) && strm_ok(STRM_W, MM_W))
    else $error("illegal bus width setting");
  burst_cap_a: assert property (
    valid_q |-> beats_q != '0 && beats_q <= BW'(MAX_BURST))
    else $error("burst longer than the configured maximum");
  cmd_hold_a: assert property (
    valid_q && !port.cmd_ready |=> valid_q && $stable(cur_q)
      && $stable(beats_q))
    else $error("burst command changed before it was taken");
  align_err_a: assert property (
    state_q == SPL_IDLE && port.start && misalign |=> err_q && !valid_q)
    else $error("unaligned start not refused");
  first_addr_a: assert property (
    state_q == SPL_IDLE && port.start && !misalign && total != '0
      |=> valid_q && cur_q == $past(port.addr))
    else $error("first burst not at the given byte address");
  last_burst_a: assert property (
    take && last |=> done_q && !valid_q ##1 !done_q)
    else $error("transfer end not flagged after last burst");
endmodule
`default_nettype wire

//--- src/sdm_top.sv
// dma option core: register slave, burst commands, delay timer
//
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - no descriptor engine: its outputs held zero
// - frame-start read sends control-stream user words
// - status packet ends write with frame-end flag
// - side streams exist only with descriptor engine
// - length width limits all length fields
// - delay tick every N clock cycles
// - simple mode never uses the delay interrupt
// - disabled read channel: outputs zero, inputs ignored
// - disabled write channel: outputs zero, inputs ignored
// - only the listed bus widths are legal
// - read realigner shifts first fetched byte out
// - write realigner stores first byte at offset
// - aligned means multiple of stream byte width
// - realign only up to 64-bit streams
// - bursts never exceed configured beat maximum
// - receive length commands exact write byte count
// - receive length removes store-and-forward buffering
module sdm_top #(
  parameter int SG_EN        = 1,
  parameter int SIDE_EN      = 1,
  parameter int USE_RXLEN    = 1,
  parameter int LEN_W        = sdm_pkg::DEF_LEN_W,
  parameter int DLY_RES      = sdm_pkg::DEF_DLY_RES,
  parameter int RD_EN        = 1,
  parameter int RD_MM_W      = sdm_pkg::DEF_MM_W,
  parameter int RD_STRM_W    = sdm_pkg::DEF_STRM_W,
  parameter int RD_REALIGN   = 1,
  parameter int RD_MAX_BURST = sdm_pkg::DEF_MAX_BURST,
  parameter int WR_EN        = 1,
  parameter int WR_MM_W      = sdm_pkg::DEF_MM_W,
  parameter int WR_STRM_W    = sdm_pkg::DEF_STRM_W,
  parameter int WR_REALIGN   = 1,
  parameter int WR_MAX_BURST = sdm_pkg::DEF_MAX_BURST
) (
  input  wire logic        CLK,
  input  wire logic        RESETN,
  input  wire logic [31:0] AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [31:0] ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RD_CMD_ADDR,
  output logic [8:0]       RD_CMD_BEATS,
  output logic             RD_CMD_VALID,
  input  wire logic        RD_CMD_READY,
  output logic [2:0]       RD_REALIGN_OFS,
  output logic [31:0]      WR_CMD_ADDR,
  output logic [8:0]       WR_CMD_BEATS,
  output logic             WR_CMD_VALID,
  input  wire logic        WR_CMD_READY,
  output logic [2:0]       WR_REALIGN_OFS,
  input  wire logic        STS_VALID,
  input  wire logic [31:0] STS_WORD4,
  output logic             CNTL_SEND,
  output logic             DELAY_TICK
);
  // options are generics only; nothing here changes them at run time
  localparam bit SG_OK    = (SG_EN != 0);
  localparam bit SIDE_OK  = SG_OK && (SIDE_EN != 0);
  localparam bit RXLEN_OK = SIDE_OK && (USE_RXLEN != 0) && (WR_EN != 0);
  localparam int DW       = $clog2(DLY_RES + 1);
  localparam int SW       = sdm_pkg::STK_W;

  function automatic logic hit(input logic [31:0] a,
                               input logic [31:0] off);
    hit = (a[31:2] == off[31:2]);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // bus slave state
  logic                awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic                aw_full_q, w_full_q, aw_full_d, w_full_d, rvalid_d;
  logic [1:0]          bresp_q, rresp_q;
  logic [31:0]         aw_addr_q, w_data_q, rdata_q, rd_mux;
  logic [3:0]          w_strb_q;
  logic                wr_fire, aw_take, w_take, ar_take, w_any, ar_any;
  logic                w_ctrl, w_stat, w_rda, w_rdl, w_wra, w_wrl;
  // block state
  logic [sdm_pkg::CTRL_W-1:0] ctrl_q;
  logic [SW-1:0]       stk_q, stk_set, stk_clr;
  logic [31:0]         rd_addr_q, wr_addr_q, ticks_q, rdl_new, wrl_new;
  logic [31:0]         cfg_word, ctrl_new;
  logic [LEN_W-1:0]    rd_len_q, wr_len_q, sts_len;
  logic                rd_start_q, wr_start_q, cntl_q, tick_q, sts_take;
  logic                tick_en, div_last;
  logic [DW-1:0]       div_q;
  sdm_cmd_if #(.LW(LEN_W)) rd_if ();
  sdm_cmd_if #(.LW(LEN_W)) wr_if ();
  // write address and data may arrive in either order
  assign aw_take   = AWVALID && awready_q;
  assign w_take    = WVALID && wready_q;
  assign ar_take   = ARVALID && arready_q;
  assign wr_fire   = aw_full_q && w_full_q && !bvalid_q;
  assign aw_full_d = aw_take || (aw_full_q && !(bvalid_q && BREADY));
  assign w_full_d  = w_take || (w_full_q && !(bvalid_q && BREADY));
  assign rvalid_d  = ar_take || (rvalid_q && !RREADY);
  assign w_ctrl = wr_fire && hit(aw_addr_q, sdm_pkg::OFF_CTRL);
  assign w_stat = wr_fire && hit(aw_addr_q, sdm_pkg::OFF_STATUS);
  assign w_rda  = wr_fire && hit(aw_addr_q, sdm_pkg::OFF_RD_ADDR);
  assign w_rdl  = wr_fire && hit(aw_addr_q, sdm_pkg::OFF_RD_LEN);
  assign w_wra  = wr_fire && hit(aw_addr_q, sdm_pkg::OFF_WR_ADDR);
  assign w_wrl  = wr_fire && hit(aw_addr_q, sdm_pkg::OFF_WR_LEN);
  assign w_any  = aw_addr_q[31:5] == '0;
  assign ar_any = ARADDR[31:5] == '0;
  assign cfg_word = (32'(LEN_W) << sdm_pkg::CFG_LEN_LSB)
                  | 32'({WR_EN != 0, RD_EN != 0, RXLEN_OK, SIDE_OK, SG_OK});
  assign rd_mux =
    hit(ARADDR, sdm_pkg::OFF_CTRL)    ? 32'(ctrl_q) :
    hit(ARADDR, sdm_pkg::OFF_STATUS)  ? 32'({stk_q, wr_if.busy, rd_if.busy}) :
    hit(ARADDR, sdm_pkg::OFF_RD_ADDR) ? rd_addr_q :
    hit(ARADDR, sdm_pkg::OFF_RD_LEN)  ? 32'(rd_len_q) :
    hit(ARADDR, sdm_pkg::OFF_WR_ADDR) ? wr_addr_q :
    hit(ARADDR, sdm_pkg::OFF_WR_LEN)  ? 32'(wr_len_q) :
    hit(ARADDR, sdm_pkg::OFF_TICKS)   ? ticks_q :
    hit(ARADDR, sdm_pkg::OFF_CONFIG)  ? cfg_word : sdm_pkg::RST_WORD;
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= sdm_pkg::RESP_OKAY;
      aw_addr_q <= sdm_pkg::RST_WORD;
      w_data_q  <= sdm_pkg::RST_WORD;
      w_strb_q  <= '0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= !aw_full_d;
      wready_q  <= !w_full_d;
      bvalid_q  <= wr_fire || (bvalid_q && !BREADY);
      bresp_q   <= !wr_fire ? bresp_q :
                   w_any ? sdm_pkg::RESP_OKAY : sdm_pkg::RESP_SLVERR;
      aw_addr_q <= aw_take ? AWADDR : aw_addr_q;
      w_data_q  <= w_take ? WDATA : w_data_q;
      w_strb_q  <= w_take ? WSTRB : w_strb_q;
    end
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= sdm_pkg::RST_WORD;
      rresp_q   <= sdm_pkg::RESP_OKAY;
    end else begin
      arready_q <= !rvalid_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= ar_take ? rd_mux : rdata_q;
      rresp_q   <= !ar_take ? rresp_q :
                   ar_any ? sdm_pkg::RESP_OKAY : sdm_pkg::RESP_SLVERR;
    end
  end

  // lengths keep only the configured number of bits
  assign rdl_new = merge(32'(rd_len_q), w_data_q, w_strb_q);
  assign wrl_new = merge(32'(wr_len_q), w_data_q, w_strb_q);
  assign ctrl_new = merge(32'(ctrl_q), w_data_q, w_strb_q);
  assign sts_len = STS_WORD4[LEN_W-1:0];
  // status word four starts the write with no packet collection
  assign sts_take = RXLEN_OK && STS_VALID && !wr_if.busy
                 && !wr_start_q && !w_wrl;
  assign stk_clr = {SW{w_stat && w_strb_q[0]}}
                 & w_data_q[sdm_pkg::ST_STK_BASE +: SW];
  always_comb begin
    stk_set = '0;
    stk_set[sdm_pkg::STK_RD_DONE]   = rd_if.done;
    stk_set[sdm_pkg::STK_WR_DONE]   = wr_if.done;
    stk_set[sdm_pkg::STK_RD_ALIGN]  = rd_if.align_err;
    stk_set[sdm_pkg::STK_WR_ALIGN]  = wr_if.align_err;
    stk_set[sdm_pkg::STK_FRAME_END] = SIDE_OK && wr_if.done;
  end
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      ctrl_q     <= sdm_pkg::RST_CTRL;
      stk_q      <= sdm_pkg::RST_STK;
      rd_addr_q  <= sdm_pkg::RST_WORD;
      wr_addr_q  <= sdm_pkg::RST_WORD;
      rd_len_q   <= '0;
      wr_len_q   <= '0;
      rd_start_q <= 1'b0;
      wr_start_q <= 1'b0;
      cntl_q     <= 1'b0;
    end else begin
      ctrl_q    <= w_ctrl ? ctrl_new[sdm_pkg::CTRL_W-1:0] : ctrl_q;
      // a new event beats a clear in the same cycle
      stk_q     <= (stk_q & ~stk_clr) | stk_set;
      rd_addr_q <= w_rda ? merge(rd_addr_q, w_data_q, w_strb_q) : rd_addr_q;
      wr_addr_q <= w_wra ? merge(wr_addr_q, w_data_q, w_strb_q) : wr_addr_q;
      // length writes during a transfer are dropped
      rd_len_q  <= (w_rdl && !rd_if.busy) ? rdl_new[LEN_W-1:0]
                                          : rd_len_q;
      wr_len_q  <= (w_wrl && !wr_if.busy) ? wrl_new[LEN_W-1:0] :
                   sts_take ? sts_len : wr_len_q;
      rd_start_q <= w_rdl && !rd_if.busy && (RD_EN != 0);
      wr_start_q <= ((w_wrl && !wr_if.busy) || sts_take)
                 && (WR_EN != 0);
      cntl_q     <= SIDE_OK && rd_start_q
                 && ctrl_q[sdm_pkg::CTRL_SOF];
    end
  end
  // delay timer only runs with the descriptor engine present
  assign tick_en  = SG_OK && ctrl_q[sdm_pkg::CTRL_TICK_EN];
  assign div_last = div_q == DW'(DLY_RES - 1);
  always_ff @(posedge CLK) begin
    if (!RESETN) begin
      div_q   <= '0;
      tick_q  <= 1'b0;
      ticks_q <= sdm_pkg::RST_WORD;
    end else begin
      div_q   <= (!tick_en || div_last) ? '0 : div_q + DW'(1);
      tick_q  <= tick_en && div_last;
      ticks_q <= ticks_q + 32'(tick_q);
    end
  end
  assign rd_if.start     = rd_start_q;
  assign rd_if.addr      = rd_addr_q;
  assign rd_if.len       = rd_len_q;
  assign rd_if.cmd_ready = RD_CMD_READY;
  assign wr_if.start     = wr_start_q;
  assign wr_if.addr      = wr_addr_q;
  assign wr_if.len       = wr_len_q;
  assign wr_if.cmd_ready = WR_CMD_READY;
  generate
    if (RD_EN != 0) begin : g_rd
      sdm_burst_split #(
        .MM_W      (RD_MM_W),
        .STRM_W    (RD_STRM_W),
        .MAX_BURST (RD_MAX_BURST),
        .LEN_W     (LEN_W),
        .REALIGN   (RD_REALIGN)
      ) u_rd (
        .clk    (CLK),
        .resetn (RESETN),
        .port   (rd_if.eng)
      );
    end else begin : g_rd_off
      assign {rd_if.busy, rd_if.done, rd_if.align_err, rd_if.cmd_addr,
              rd_if.cmd_beats, rd_if.cmd_valid, rd_if.ofs} = '0;
    end
    if (WR_EN != 0) begin : g_wr
      sdm_burst_split #(
        .MM_W      (WR_MM_W),
        .STRM_W    (WR_STRM_W),
        .MAX_BURST (WR_MAX_BURST),
        .LEN_W     (LEN_W),
        .REALIGN   (WR_REALIGN)
      ) u_wr (
        .clk    (CLK),
        .resetn (RESETN),
        .port   (wr_if.eng)
      );
    end else begin : g_wr_off
      assign {wr_if.busy, wr_if.done, wr_if.align_err, wr_if.cmd_addr,
              wr_if.cmd_beats, wr_if.cmd_valid, wr_if.ofs} = '0;
    end
  endgenerate
  assign AWREADY        = awready_q;
  assign WREADY         = wready_q;
  assign BVALID         = bvalid_q;
  assign BRESP          = bresp_q;
  assign ARREADY        = arready_q;
  assign RVALID         = rvalid_q;
  assign RDATA          = rdata_q;
  assign RRESP          = rresp_q;
  assign RD_CMD_ADDR    = rd_if.cmd_addr;
  assign RD_CMD_BEATS   = rd_if.cmd_beats;
  assign RD_CMD_VALID   = rd_if.cmd_valid;
  assign RD_REALIGN_OFS = rd_if.ofs;
  assign WR_CMD_ADDR    = wr_if.cmd_addr;
  assign WR_CMD_BEATS   = wr_if.cmd_beats;
  assign WR_CMD_VALID   = wr_if.cmd_valid;
  assign WR_REALIGN_OFS = wr_if.ofs;
  // descriptor-engine side outputs stay zero when it is absent
  assign CNTL_SEND      = cntl_q;
  assign DELAY_TICK     = tick_q;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  sequence fire_s;
    wr_fire;
  endsequence
  sequence resp_s;
    BVALID && !AWREADY && !WREADY;
  endsequence
  bus_write_a: assert property (fire_s |=> resp_s)
    else $error("write answer missing one cycle after both parts");
  tick_period_a: assert property (
    tick_en && div_last |=> DELAY_TICK && div_q == '0)
    else $error("delay tick not on the resolution boundary");
  no_tick_a: assert property (!tick_en |=> !DELAY_TICK)
    else $error("delay tick while the timer is stopped");
  side_a: assert property (
    CNTL_SEND |-> SIDE_OK && $past(rd_start_q))
    else $error("control stream used without a read start");
  sof_send_a: assert property (
    SIDE_OK && rd_start_q && ctrl_q[sdm_pkg::CTRL_SOF] |=> CNTL_SEND)
    else $error("frame-start read sent no control words");
  frame_end_a: assert property (
    SIDE_OK && wr_if.done |=> stk_q[sdm_pkg::STK_FRAME_END])
    else $error("frame-end flag not set at write end");
  rxlen_a: assert property (
    sts_take |=> wr_start_q && wr_len_q == $past(sts_len))
    else $error("receive length not commanded");
  rd_off_a: assert property ((RD_EN == 0) |-> !RD_CMD_VALID)
    else $error("disabled read channel drives a command");
  wr_off_a: assert property ((WR_EN == 0) |-> !WR_CMD_VALID)
    else $error("disabled write channel drives a command");
endmodule
`default_nettype wire

//--- tb/sdm_mem_model.sv
// memory side model: accepts burst commands with random stalls
`timescale 1ns/100ps
`default_nettype none
module sdm_mem_model (
  input  wire logic CLK,
  input  wire logic CMD_VALID,
  output logic      CMD_READY
);
  // same clock as the core, one source for every port
  initial CMD_READY = 1'b0;
  always @(posedge CLK) begin
    // ready only after a command shows, so the first burst of each transfer sees a stall first
    CMD_READY <= CMD_VALID && (($urandom % 3) != 0);
  end
endmodule
`default_nettype wire

//--- tb/sdm_top_tb.sv
// self-checking bench for the dma option core
`timescale 1ns/100ps
`default_nettype none
module sdm_top_tb;
  logic CLK = 0, RESETN = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0;
  logic RREADY = 0, STS_VALID = 0, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [31:0] AWADDR = 0, WDATA = 0, ARADDR = 0, STS_WORD4 = 0, RDATA, rd_v;
  logic [1:0]  BRESP, RRESP, rsp;
  logic [3:0]  WSTRB = 4'hf;
  logic [31:0] RD_CMD_ADDR, WR_CMD_ADDR;
  logic [8:0]  RD_CMD_BEATS, WR_CMD_BEATS;
  logic [2:0]  RD_REALIGN_OFS, WR_REALIGN_OFS;
  logic RD_CMD_VALID, RD_CMD_READY, WR_CMD_VALID, WR_CMD_READY, CNTL_SEND;
  logic DELAY_TICK;
  logic [43:0] cq[2][$];
  int fails = 0, checks = 0, cyc = 0, last_tick = 0, gap = 0, sends = 0;
  always #2 CLK = ~CLK; // one clock for every port
  sdm_top #(.DLY_RES(4)) sdm_top_i (.CLK(CLK), .RESETN(RESETN),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .RD_CMD_ADDR(RD_CMD_ADDR), .RD_CMD_BEATS(RD_CMD_BEATS),
    .RD_CMD_VALID(RD_CMD_VALID), .RD_CMD_READY(RD_CMD_READY),
    .RD_REALIGN_OFS(RD_REALIGN_OFS), .WR_CMD_ADDR(WR_CMD_ADDR),
    .WR_CMD_BEATS(WR_CMD_BEATS), .WR_CMD_VALID(WR_CMD_VALID),
    .WR_CMD_READY(WR_CMD_READY), .WR_REALIGN_OFS(WR_REALIGN_OFS),
    .STS_VALID(STS_VALID), .STS_WORD4(STS_WORD4), .CNTL_SEND(CNTL_SEND),
    .DELAY_TICK(DELAY_TICK));
  sdm_mem_model rd_mem_i (.CLK(CLK), .CMD_VALID(RD_CMD_VALID),
    .CMD_READY(RD_CMD_READY));
  sdm_mem_model wr_mem_i (.CLK(CLK), .CMD_VALID(WR_CMD_VALID),
    .CMD_READY(WR_CMD_READY));
  always @(posedge CLK) begin
    if (RD_CMD_VALID && RD_CMD_READY)
      cq[0].push_back({RD_REALIGN_OFS, RD_CMD_ADDR, RD_CMD_BEATS});
    if (WR_CMD_VALID && WR_CMD_READY)
      cq[1].push_back({WR_REALIGN_OFS, WR_CMD_ADDR, WR_CMD_BEATS});
    if (CNTL_SEND) sends++;
    if (DELAY_TICK) begin
      gap = cyc - last_tick;
      last_tick = cyc;
    end
    cyc++;
    // ceiling well above the few hundred cycles the tests need
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    AWADDR <= a; WDATA <= d; AWVALID <= 1; WVALID <= 1; BREADY <= 1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 0;
      if (WREADY) WVALID <= 0;
    end while (!BVALID);
    rsp = BRESP;
    BREADY <= 0;
  endtask
  task automatic rd(input logic [31:0] a);
    ARADDR <= a; ARVALID <= 1; RREADY <= 1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 0;
    end while (!RVALID);
    rd_v = RDATA; rsp = RRESP;
    RREADY <= 0;
  endtask
  // expected bursts: later ones start on the next word after the last
  task automatic expect_cmds(input int ch, input logic [31:0] a, input int len);
    logic [31:0] ea; logic [43:0] g; int tot, n, k;
    ea = a; tot = (len + a % 4 + 3) / 4;
    while (tot > 0) begin
      n = tot > 16 ? 16 : tot;
      k = 0;
      while (cq[ch].size() == 0 && k < 500) begin @(posedge CLK); k++; end
      g = cq[ch].size() > 0 ? cq[ch].pop_front() : '1;
      chk("cmd_addr", ea, g[40:9]);
      chk("cmd_beats", n, {23'h0, g[8:0]});
      if (ea == a) chk("start_ofs", a % 4, {29'h0, g[43:41]});
      ea = (ea & ~32'h3) + 4 * n; tot -= n;
    end
  endtask
  task automatic run(input int ch, input logic [31:0] a, input int len);
    wr(ch ? sdm_pkg::OFF_WR_ADDR : sdm_pkg::OFF_RD_ADDR, a);
    wr(ch ? sdm_pkg::OFF_WR_LEN : sdm_pkg::OFF_RD_LEN, len);
    expect_cmds(ch, a, len);
  endtask
  initial begin
    void'($urandom(32'hfa09));
    repeat (4) @(posedge CLK);
    RESETN <= 1;
    rd(sdm_pkg::OFF_CONFIG);
    chk("config", 32'h0000_0e1f, rd_v);
    wr(sdm_pkg::OFF_CTRL, 32'h3);
    chk("ok_bresp", 32'h0, {30'h0, rsp});
    run(0, 32'h100, 100);
    run(0, 32'h102, 8);
    run(1, 32'h13, 20);
    for (int i = 0; i < 6; i++)
      run(i % 2, $urandom & 32'hfff, 1 + $urandom % 300);
    chk("cntl_sends", 5, sends);
    // clear every sticky flag so the frame-end check sees only this packet
    wr(sdm_pkg::OFF_STATUS, 32'h7c);
    wr(sdm_pkg::OFF_WR_ADDR, 32'h200);
    STS_WORD4 <= 32'd77; STS_VALID <= 1;
    @(posedge CLK);
    STS_VALID <= 0;
    expect_cmds(1, 32'h200, 77);
    repeat (3) @(posedge CLK);
    rd(sdm_pkg::OFF_STATUS);
    chk("frame_end", 32'h48, rd_v & 32'h7c);
    chk("tick_gap", 4, gap);
    rd(32'h40);
    chk("bad_resp", 32'h2, {30'h0, rsp});
    chk("bad_data", 32'h0, rd_v);
    wr(32'h40, 32'h0);
    chk("bad_bresp", 32'h2, {30'h0, rsp});
    complete_run();
  end
endmodule
`default_nettype wire
